// ### dpsc_map.svh
// constants for the dual pot serial command logic
// assumes inclusion by the package and the design modules
`ifndef DPSC_MAP_SVH
`define DPSC_MAP_SVH

`define DPSC_CLK_HZ 20000000
`define DPSC_WC_TIME_US 5000
`define DPSC_WC_CYCLES ((`DPSC_WC_TIME_US * (`DPSC_CLK_HZ / 1000000)))
`define DPSC_SETTLE_NS 5000
`define DPSC_SETTLE_CYCLES ((`DPSC_SETTLE_NS * (`DPSC_CLK_HZ / 1000000)) / 1000)
`define DPSC_PU_TIME_US 1000
`define DPSC_PU_CYCLES ((`DPSC_PU_TIME_US * (`DPSC_CLK_HZ / 1000000)))
`define DPSC_TYPE_ID_DEF 4'hA
`define DPSC_OP_RD_WPR 4'h9
`define DPSC_OP_WR_WPR 4'hA
`define DPSC_OP_RD_SLOT 4'hB
`define DPSC_OP_WR_SLOT 4'hC
`define DPSC_OP_XFR_S2W 4'hD
`define DPSC_OP_XFR_W2S 4'hE
`define DPSC_OP_GXFR_S2W 4'h1
`define DPSC_OP_GXFR_W2S 4'h8
`define DPSC_OP_INCDEC 4'h2
`define DPSC_OP_STATUS 4'h5
`define DPSC_SLOT_ZERO 2'h0
`define DPSC_BIT_CNT_LAST 3'h7
`define DPSC_POS_MAX 6'h3F
`define DPSC_POS_MIN 6'h00

`endif

// ### dpsc_pkg.sv
// types for the dual pot serial command logic
// assumes dpsc_map.svh is reachable on the include path
`include "dpsc_map.svh"
package dpsc_pkg;
  typedef logic [5:0] dpsc_pos_t;
  typedef logic [3:0] dpsc_op_t;
  typedef enum logic [2:0] {
    DPSC_ST_ADDR = 3'h0,
    DPSC_ST_INSTR = 3'h1,
    DPSC_ST_DATA = 3'h2,
    DPSC_ST_INCDEC = 3'h3,
    DPSC_ST_DONE = 3'h4,
    DPSC_ST_IGNORE = 3'h5
  } dpsc_state_e;
endpackage

// ### dpsc_nv_store.sv
// nonvolatile slot array with timed write cycle
// assumes single clock; write requests come as one-cycle pulses
`timescale 1ns/1ns
`include "dpsc_map.svh"
module dpsc_nv_store #(
  parameter int WC_CYCLES = `DPSC_WC_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wr_req,
  input wire logic [7:0] wr_mask,
  input wire logic [47:0] wr_data,
  output logic busy,
  output logic [47:0] slots
);
  import dpsc_pkg::*;
  logic [47:0] slots_r, slots_nxt;
  logic [47:0] pend_r, pend_nxt;
  logic [7:0] mask_r, mask_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt;

  always_comb begin
    slots_nxt = slots_r;
    pend_nxt = pend_r;
    mask_nxt = mask_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    if (busy_r) begin
      if (cnt_r == 32'h0) begin
        busy_nxt = 1'b0;
        for (int i = 0; i < 8; i++) begin
          if (mask_r[i]) begin
            slots_nxt[i*6 +: 6] = pend_r[i*6 +: 6];
          end
        end
      end else begin
        cnt_nxt = cnt_r - 32'h1;
      end
    end else if (wr_req) begin
      busy_nxt = 1'b1;
      pend_nxt = wr_data;
      mask_nxt = wr_mask;
      cnt_nxt = 32'(WC_CYCLES - 2);
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      slots_r <= 48'h0;
      pend_r <= 48'h0;
      mask_r <= 8'h00;
      cnt_r <= 32'h0;
      busy_r <= 1'b0;
    end else begin
      slots_r <= slots_nxt;
      pend_r <= pend_nxt;
      mask_r <= mask_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

  assign busy = busy_r;
  assign slots = slots_r;

  // length of the running write cycle, for the bound check
  logic [31:0] busy_len_r, busy_len_nxt;

  always_comb begin
    busy_len_nxt = busy_r ? busy_len_r + 32'h1 : 32'h0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_len_r <= 32'h0;
    end else begin
      busy_len_r <= busy_len_nxt;
    end
  end

  a_wc_bound: assert property (@(posedge clock) disable iff (!rst_n)
    busy_len_r < 32'(WC_CYCLES)) else $error("write cycle too long");
endmodule

// ### dpsc_core.sv
// serial command front end and wiper registers of a dual 64-tap pot
// assumes serial pins sampled synchronously to clock; dpsc_nv_store present
`timescale 1ns/1ns
`include "dpsc_map.svh"
//
// Overview of operation
// - first byte upper nibble is type identifier
// - execute only when strap bits match
// - second byte upper nibble is opcode
// - slot bits pick slot zero to three
// - low instruction bit selects the pot
// - 6-bit wiper decoded one-hot to 64 taps
// - write-wiper loads data into wiper
// - transfer copies slot into wiper
// - increment/decrement moves one position per step
// - power-up loads wiper from slot zero
// - wipers are volatile, reloaded after power loss
// - four host-accessible nonvolatile slots per pot
// - copy either way between slot and wiper
// - slot change is write cycle under 5 ms
// - save starts when chip select rises
// - read-status returns write-pending flag
// - stepped wiper settles within 5 us
// - pending flag high during write cycle
// - data high steps up, low steps down
module dpsc_core #(
  parameter logic [3:0] TYPE_ID = `DPSC_TYPE_ID_DEF, // arbitrary value
  parameter int WC_CYCLES = `DPSC_WC_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic [1:0] strap_address_bits,
  output logic so,
  output logic so_oe,
  output logic write_pending_flag,
  output logic [63:0] tap_sel0,
  output logic [63:0] tap_sel1
);
  import dpsc_pkg::*;

  ////////////////////////////////////////////////////////////////
  // pin edge detection
  logic sck_d_r, sck_d_nxt, cs_d_r, cs_d_nxt;
  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = sck & ~sck_d_r;
  assign sck_fall = ~sck & sck_d_r;
  assign cs_rise = cs_n & ~cs_d_r;

  ////////////////////////////////////////////////////////////////
  // command state
  dpsc_state_e st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt;
  logic [2:0] bit_r, bit_nxt;
  dpsc_op_t op_r, op_nxt;
  logic [1:0] slot_r, slot_nxt;
  logic pot_r, pot_nxt;
  logic [7:0] out_r, out_nxt;
  logic so_r, so_nxt, oe_r, oe_nxt;
  dpsc_pos_t wpr_r [2], wpr_nxt [2];
  logic init_r, init_nxt;
  logic save_arm_r, save_arm_nxt;
  logic [7:0] save_mask_r, save_mask_nxt;
  logic [47:0] save_data_r, save_data_nxt;
  logic nv_req;
  logic [47:0] slots;
  logic nv_busy;
  logic pend_r, pend_nxt;
  logic [63:0] tap0_r, tap0_nxt, tap1_r, tap1_nxt;
  logic [7:0] byte_in;
  assign byte_in = {sh_r[6:0], si};

  dpsc_nv_store #(.WC_CYCLES(WC_CYCLES)) u_nv (
    .clock(clock),
    .rst_n(rst_n),
    .wr_req(nv_req),
    .wr_mask(save_mask_r),
    .wr_data(save_data_r),
    .busy(nv_busy),
    .slots(slots)
  );

  function automatic dpsc_pos_t slot_of(input logic [47:0] s, input logic p, input logic [1:0] k);
    slot_of = s[{p, k}*6 +: 6];
  endfunction

  always_comb begin
    sck_d_nxt = sck;
    cs_d_nxt = cs_n;
    st_nxt = st_r;
    sh_nxt = sh_r;
    bit_nxt = bit_r;
    op_nxt = op_r;
    slot_nxt = slot_r;
    pot_nxt = pot_r;
    out_nxt = out_r;
    so_nxt = so_r;
    oe_nxt = oe_r;
    wpr_nxt = wpr_r;
    init_nxt = 1'b1;
    save_arm_nxt = save_arm_r;
    save_mask_nxt = save_mask_r;
    save_data_nxt = save_data_r;
    nv_req = 1'b0;
    pend_nxt = nv_busy | nv_req;
    if (!init_r) begin
      wpr_nxt[0] = slot_of(slots, 1'b0, `DPSC_SLOT_ZERO);
      wpr_nxt[1] = slot_of(slots, 1'b1, `DPSC_SLOT_ZERO);
    end
    if (cs_n) begin
      st_nxt = DPSC_ST_ADDR;
      bit_nxt = 3'h0;
      oe_nxt = 1'b0;
      if (cs_rise && save_arm_r && !nv_busy) begin
        nv_req = 1'b1;
        save_arm_nxt = 1'b0;
      end else if (cs_rise) begin
        save_arm_nxt = 1'b0;
      end
      pend_nxt = nv_busy | nv_req;
    end else if (sck_fall && oe_r) begin
      so_nxt = out_r[3'h7 - bit_r];
    end else if (sck_rise) begin
      sh_nxt = byte_in;
      bit_nxt = bit_r + 3'h1;
      if (st_r == DPSC_ST_INCDEC) begin
        if (si && wpr_r[pot_r] != `DPSC_POS_MAX) begin
          wpr_nxt[pot_r] = wpr_r[pot_r] + 6'h01;
        end else if (!si && wpr_r[pot_r] != `DPSC_POS_MIN) begin
          wpr_nxt[pot_r] = wpr_r[pot_r] - 6'h01;
        end
      end else if (bit_r == `DPSC_BIT_CNT_LAST) begin
        unique case (st_r)
          DPSC_ST_ADDR: begin
            if (byte_in[7:4] == TYPE_ID && byte_in[1:0] == strap_address_bits) begin
              st_nxt = DPSC_ST_INSTR;
            end else begin
              st_nxt = DPSC_ST_IGNORE;
            end
          end
          DPSC_ST_INSTR: begin
            op_nxt = byte_in[7:4];
            slot_nxt = byte_in[3:2];
            pot_nxt = byte_in[0];
            st_nxt = DPSC_ST_DONE;
            oe_nxt = 1'b0;
            unique case (byte_in[7:4])
              `DPSC_OP_RD_WPR: begin
                st_nxt = DPSC_ST_DATA;
                out_nxt = {2'h0, wpr_r[byte_in[0]]};
                oe_nxt = 1'b1;
              end
              `DPSC_OP_RD_SLOT: begin
                st_nxt = DPSC_ST_DATA;
                out_nxt = {2'h0, slot_of(slots, byte_in[0], byte_in[3:2])};
                oe_nxt = 1'b1;
              end
              `DPSC_OP_STATUS: begin
                st_nxt = DPSC_ST_DATA;
                out_nxt = {7'h00, pend_r};
                oe_nxt = 1'b1;
              end
              `DPSC_OP_WR_WPR, `DPSC_OP_WR_SLOT: st_nxt = DPSC_ST_DATA;
              `DPSC_OP_XFR_S2W: wpr_nxt[byte_in[0]] = slot_of(slots, byte_in[0], byte_in[3:2]);
              `DPSC_OP_GXFR_S2W: begin
                wpr_nxt[0] = slot_of(slots, 1'b0, byte_in[3:2]);
                wpr_nxt[1] = slot_of(slots, 1'b1, byte_in[3:2]);
              end
              `DPSC_OP_XFR_W2S: begin
                save_arm_nxt = 1'b1;
                save_mask_nxt = 8'h01 << {byte_in[0], byte_in[3:2]};
                save_data_nxt = slots;
                save_data_nxt[{byte_in[0], byte_in[3:2]}*6 +: 6] = wpr_r[byte_in[0]];
              end
              `DPSC_OP_GXFR_W2S: begin
                save_arm_nxt = 1'b1;
                save_mask_nxt = (8'h01 << {1'b0, byte_in[3:2]}) | (8'h01 << {1'b1, byte_in[3:2]});
                save_data_nxt = slots;
                save_data_nxt[{1'b0, byte_in[3:2]}*6 +: 6] = wpr_r[0];
                save_data_nxt[{1'b1, byte_in[3:2]}*6 +: 6] = wpr_r[1];
              end
              `DPSC_OP_INCDEC: st_nxt = DPSC_ST_INCDEC;
              default: st_nxt = DPSC_ST_IGNORE;
            endcase
          end
          DPSC_ST_DATA: begin
            st_nxt = DPSC_ST_DONE;
            oe_nxt = 1'b0;
            if (op_r == `DPSC_OP_WR_WPR) begin
              wpr_nxt[pot_r] = byte_in[5:0];
            end else if (op_r == `DPSC_OP_WR_SLOT) begin
              save_arm_nxt = 1'b1;
              save_mask_nxt = 8'h01 << {pot_r, slot_r};
              save_data_nxt = slots;
              save_data_nxt[{pot_r, slot_r}*6 +: 6] = byte_in[5:0];
            end
          end
          default: st_nxt = st_r;
        endcase
      end
    end
  end

  // one-hot tap decode per pot
  always_comb begin
    tap0_nxt = 64'h0;
    tap1_nxt = 64'h0;
    tap0_nxt[wpr_nxt[0]] = 1'b1;
    tap1_nxt[wpr_nxt[1]] = 1'b1;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      st_r <= DPSC_ST_ADDR;
      sh_r <= 8'h00;
      bit_r <= 3'h0;
      op_r <= 4'h0;
      slot_r <= 2'h0;
      pot_r <= 1'b0;
      out_r <= 8'h00;
      so_r <= 1'b0;
      oe_r <= 1'b0;
      wpr_r[0] <= 6'h00;
      wpr_r[1] <= 6'h00;
      init_r <= 1'b0;
      save_arm_r <= 1'b0;
      save_mask_r <= 8'h00;
      save_data_r <= 48'h0;
      pend_r <= 1'b0;
      tap0_r <= 64'h1;
      tap1_r <= 64'h1;
    end else begin
      sck_d_r <= sck_d_nxt;
      cs_d_r <= cs_d_nxt;
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      bit_r <= bit_nxt;
      op_r <= op_nxt;
      slot_r <= slot_nxt;
      pot_r <= pot_nxt;
      out_r <= out_nxt;
      so_r <= so_nxt;
      oe_r <= oe_nxt;
      wpr_r <= wpr_nxt;
      init_r <= init_nxt;
      save_arm_r <= save_arm_nxt;
      save_mask_r <= save_mask_nxt;
      save_data_r <= save_data_nxt;
      pend_r <= pend_nxt;
      tap0_r <= tap0_nxt;
      tap1_r <= tap1_nxt;
    end
  end

  assign so = so_r;
  assign so_oe = oe_r;
  assign write_pending_flag = pend_r;
  assign tap_sel0 = tap0_r;
  assign tap_sel1 = tap1_r;

  ////////////////////////////////////////////////////////////////
  // checks
  a_tap_onehot: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot(tap0_r) && $onehot(tap1_r)) else $error("tap select not one-hot");
  a_step_one: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == DPSC_ST_INCDEC && !cs_n |=> (wpr_r[pot_r] - $past(wpr_r[pot_r]) <= 6'h01)
      || ($past(wpr_r[pot_r]) - wpr_r[pot_r] <= 6'h01)) else $error("step larger than one");
  a_step_up: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == DPSC_ST_INCDEC && !cs_n && sck_rise && si && wpr_r[pot_r] != `DPSC_POS_MAX
      |=> wpr_r[pot_r] == $past(wpr_r[pot_r]) + 6'h01) else $error("step up missed");
  a_step_settle: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == DPSC_ST_INCDEC && !cs_n && sck_rise && !pot_r && !si && wpr_r[0] != `DPSC_POS_MIN
      |=> tap0_r == (64'h1 << ($past(wpr_r[0]) - 6'h01))) else $error("tap did not settle");
  a_bad_strap: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == DPSC_ST_ADDR && !cs_n && sck_rise && bit_r == `DPSC_BIT_CNT_LAST
      && byte_in[1:0] != strap_address_bits |=> st_r == DPSC_ST_IGNORE) else $error("strap mismatch accepted");
  a_bad_type: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == DPSC_ST_ADDR && !cs_n && sck_rise && bit_r == `DPSC_BIT_CNT_LAST
      && byte_in[7:4] != TYPE_ID |=> st_r != DPSC_ST_INSTR) else $error("wrong type accepted");
  a_save_on_cs: assert property (@(posedge clock) disable iff (!rst_n)
    nv_req |-> cs_rise) else $error("save started without chip select rise");
  a_pend_flag: assert property (@(posedge clock) disable iff (!rst_n)
    nv_req |=> pend_r [*2]) else $error("pending flag not set");
  a_powerup_load: assert property (@(posedge clock) disable iff (!rst_n)
    !init_r |=> wpr_r[0] == $past(slots[5:0])) else $error("power-up recall missing");
  c_incdec: cover property (@(posedge clock) disable iff (!rst_n) st_r == DPSC_ST_INCDEC && sck_rise);
  c_save: cover property (@(posedge clock) disable iff (!rst_n) nv_req);
  c_status: cover property (@(posedge clock) disable iff (!rst_n) oe_r && op_r == `DPSC_OP_STATUS);
  c_ignore: cover property (@(posedge clock) disable iff (!rst_n) st_r == DPSC_ST_IGNORE);
  a_ignore_hold: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == DPSC_ST_IGNORE && !cs_n |=> st_r == DPSC_ST_IGNORE) else $error("ignored frame resumed");
  a_wiper_write: assert property (@(posedge clock) disable iff (!rst_n)
    st_r == DPSC_ST_DATA && op_r == `DPSC_OP_WR_WPR && !cs_n && sck_rise && bit_r == `DPSC_BIT_CNT_LAST
      |=> wpr_r[pot_r] == $past(byte_in[5:0])) else $error("wiper write lost");
  a_oe_off: assert property (@(posedge clock) disable iff (!rst_n)
    cs_n |=> !oe_r) else $error("output enabled outside frame");
endmodule

// ### dpsc_host_model.sv
// host-side serial master model, mode 0 frames, msb first
// assumes a free-running clock; tasks are entered just after a rising edge
`timescale 1ns/1ns
module dpsc_host_model (
  input wire logic clock,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  output logic rd_stb,
  output logic [7:0] rd_byte
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    rd_stb = 1'b0;
    rd_byte = 8'h00;
  end
  // released data line toggles so no stale bit lingers
  always @(posedge clock) begin
    if (cs_n) si <= #5 ~si;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  // sck parks low outside frames, stays 4 clocks low and 3 high
  task automatic pulse(input logic b, output logic s);
    si = b;
    tick(4);
    s = so;
    sck = 1'b1;
    tick(3);
    sck = 1'b0;
  endtask
  task automatic open(input logic [23:0] w, input int nb, input logic rd);
    logic s;
    logic [7:0] r;
    r = 8'h00;
    cs_n = 1'b0;
    tick(3);
    for (int k = 0; k < nb * 8; k++) begin
      pulse(w[23 - k], s);
      r = {r[6:0], s};
    end
    rd_byte = r;
    rd_stb = rd;
    tick(1);
    rd_stb = 1'b0;
  endtask
  task automatic close();
    tick(2);
    cs_n = 1'b1;
    tick(6);
  endtask
endmodule

// ### dual_pot_serial_command_logic_tb_top.sv
// self-checking bench for the dual pot serial command core
// assumes dpsc_pkg, dpsc_nv_store, dpsc_core and dpsc_host_model compiled first
`timescale 1ns/1ns
`include "dpsc_map.svh"
module dual_pot_serial_command_logic_tb_top;
  import dpsc_pkg::*;
  localparam int WC = 400;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] strap = 2'h0;
  logic cs_n, sck, si, so, so_oe, write_pending_flag, rd_stb;
  logic so_bus;
  logic cs_q = 1'b1;
  logic [7:0] rd_byte, e;
  logic [63:0] tap_sel0, tap_sel1;
  dpsc_pos_t pos [2];
  dpsc_pos_t sv [4];
  logic [7:0] exp_q [$];
  int n_mismatch = 0;
  int compares = 0;
  int wp_cnt = 0;
  int seed;
  always #25 clock = ~clock;
  dpsc_core #(.WC_CYCLES(WC)) i_dpsc_core (.clock(clock), .rst_n(rst_n), .cs_n(cs_n), .sck(sck), .si(si),
    .strap_address_bits(strap), .so(so), .so_oe(so_oe), .write_pending_flag(write_pending_flag),
    .tap_sel0(tap_sel0), .tap_sel1(tap_sel1));
  // released data line shows the inverse of the last bit
  assign so_bus = so_oe ? so : ~so;
  dpsc_host_model i_dpsc_host_model (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so_bus),
    .rd_stb(rd_stb), .rd_byte(rd_byte));
  //////////////////////////////////////////////////////////////
  always @(posedge clock) begin
    if (rst_n === 1'b1 && cs_q && cs_n === 1'b1 && so_oe !== 1'b0) fail("so_oe outside frame");
    cs_q <= cs_n;
  end
  always @(posedge clock) begin
    if (write_pending_flag === 1'b1) wp_cnt <= wp_cnt + 1;
  end
  // watcher: every strobed read byte is matched with the oldest note
  always @(posedge clock) begin
    if (rd_stb === 1'b1) begin
      compares++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
      if (rd_byte !== e) fail("read byte");
    end
  end
  task automatic fail(input string m);
    n_mismatch++;
    $display("MISMATCH %0t %s", $time, m);
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [7:0] adr(input logic [1:0] s);
    return {`DPSC_TYPE_ID_DEF, 2'b00, s};
  endfunction
  task automatic run(input logic [7:0] a, input dpsc_op_t op, input logic [1:0] sl, input logic p,
                     input dpsc_pos_t d, input int nb);
    i_dpsc_host_model.open({a, op, sl, 1'b0, p, 2'b00, d}, nb, 1'b0);
    i_dpsc_host_model.close();
  endtask
  task automatic rd(input dpsc_op_t op, input logic [1:0] sl, input logic p, input dpsc_pos_t x);
    exp_q.push_back({2'b00, x});
    i_dpsc_host_model.open({adr(strap), op, sl, 1'b0, p, 8'h00}, 3, 1'b1);
    i_dpsc_host_model.close();
  endtask
  task automatic tap(input logic p, input dpsc_pos_t x);
    compares++;
    if ((p ? tap_sel1 : tap_sel0) !== (64'h1 << x)) fail("tap select");
  endtask
  task automatic status(input logic f);
    i_dpsc_host_model.open({adr(strap), `DPSC_OP_STATUS, 4'h1, 8'h00}, 3, 1'b0);
    i_dpsc_host_model.close();
    compares++;
    if (i_dpsc_host_model.rd_byte !== {7'h00, f}) fail("status flag");
  endtask
  task automatic nvw(input dpsc_op_t op, input logic [1:0] sl, input logic p, input dpsc_pos_t d);
    wp_cnt = 0;
    run(adr(strap), op, sl, p, d, (op == `DPSC_OP_WR_SLOT) ? 3 : 2);
    status(1'b1);
    for (int k = 0; k < WC + 100 && write_pending_flag !== 1'b0; k++) begin
      @(posedge clock);
      #5;
    end
    compares++;
    if (wp_cnt !== WC) fail("write cycle length");
    status(1'b0);
  endtask
  task automatic step(input logic p, input dpsc_pos_t x, input logic [7:0] dirs, input int n);
    logic s;
    run(adr(strap), `DPSC_OP_WR_WPR, 2'h0, p, x, 3);
    i_dpsc_host_model.open({adr(strap), `DPSC_OP_INCDEC, 2'h0, 1'b0, p, 8'h00}, 2, 1'b0);
    for (int k = 0; k < n; k++) begin
      i_dpsc_host_model.pulse(dirs[k], s);
      if (dirs[k] && x != `DPSC_POS_MAX) x++;
      if (!dirs[k] && x != `DPSC_POS_MIN) x--;
      tap(p, x);
    end
    i_dpsc_host_model.close();
  endtask
  //////////////////////////////////////////////////////////////
  initial begin
    seed = $urandom(32'h2bc7);
    strap = 2'($urandom);
    repeat (4) @(posedge clock);
    #5;
    rst_n = 1'b1;
    i_dpsc_host_model.tick(3);
    tap(1'b0, 6'h00);
    tap(1'b1, 6'h00);
    i_dpsc_host_model.tick(`DPSC_PU_CYCLES);
    for (int p = 0; p < 2; p++) begin
      pos[p] = 6'($urandom);
      run(adr(strap), `DPSC_OP_WR_WPR, 2'h0, p[0], pos[p], 3);
      tap(p[0], pos[p]);
      rd(`DPSC_OP_RD_WPR, 2'h0, p[0], pos[p]);
    end
    run({~`DPSC_TYPE_ID_DEF, 2'b00, strap}, `DPSC_OP_WR_WPR, 2'h0, 1'b0, ~pos[0], 3);
    run(adr(~strap), `DPSC_OP_WR_WPR, 2'h0, 1'b0, ~pos[0], 3);
    tap(1'b0, pos[0]);
    for (int s = 0; s < 4; s++) begin
      sv[s] = 6'($urandom);
      nvw(`DPSC_OP_WR_SLOT, s[1:0], 1'b0, sv[s]);
      rd(`DPSC_OP_RD_SLOT, s[1:0], 1'b0, sv[s]);
    end
    for (int s = 3; s >= 0; s--) begin
      run(adr(strap), `DPSC_OP_XFR_S2W, s[1:0], 1'b0, 6'h00, 2);
      tap(1'b0, sv[s]);
    end
    nvw(`DPSC_OP_XFR_W2S, 2'h2, 1'b1, 6'h00);
    rd(`DPSC_OP_RD_SLOT, 2'h2, 1'b1, pos[1]);
    run(adr(strap), `DPSC_OP_GXFR_S2W, 2'h2, 1'b0, 6'h00, 2);
    tap(1'b0, sv[2]);
    tap(1'b1, pos[1]);
    nvw(`DPSC_OP_GXFR_W2S, 2'h1, 1'b0, 6'h00);
    rd(`DPSC_OP_RD_SLOT, 2'h1, 1'b0, sv[2]);
    rd(`DPSC_OP_RD_SLOT, 2'h1, 1'b1, pos[1]);
    step(1'b0, 6'h3E, 8'h03, 5);
    step(1'b1, 6'h01, 8'h00, 2);
    rst_n = 1'b0;
    i_dpsc_host_model.tick(2);
    rst_n = 1'b1;
    i_dpsc_host_model.tick(3);
    tap(1'b0, 6'h00);
    tap(1'b1, 6'h00);
    give_verdict();
  end
  initial begin
    i_dpsc_host_model.tick(90000);
    fail("timeout");
    give_verdict();
  end
endmodule
